// ### design/tpr_bank.sv
// Register bank of the thermopile signal core, reached over the byte link.
// Assumes readings and filter outputs arrive synchronous to pclk with a sample strobe.
`timescale 1ns/1ps
module tpr_bank (
   input wire logic pclk,
   input wire logic presetn,
   tpr_link_if.dev link,
   input wire logic sample_stb,
   input wire logic [16:0] object_raw_reading,
   input wire logic [14:0] ambient_raw_reading,
   input wire logic [19:0] object_filter_one,
   input wire logic [19:0] object_filter_two,
   input wire logic [15:0] ambient_filter_three,
   input wire logic [247:0] nonvolatile_window,
   input wire logic [7:0] bus_address_readback,
   output logic [3:0] filter_one_select,
   output logic [3:0] filter_two_select,
   output logic [3:0] filter_three_select,
   output logic [7:0] nonvolatile_access_control
);
   import tpr_pkg::*;

   // ****************************************
   // Sampling
   // ****************************************
   logic burst_q;
   logic [5:0] ptr_q;
   logic [16:0] obj_q;
   logic [14:0] amb_q;
   logic [19:0] lp1_q, lp2_q, prev_lp1_q;
   logic [15:0] lp3_q;
   logic [23:0] cap_q;
   logic [7:0] pres_q, move_q, step_q, live_q, latch_q;
   logic [7:0] pres_limit_q, move_limit_q, step_limit_q, periodic_q, rsp_data_q;
   logic [4:0] mask_q;
   logic [1:0] interval_q, source_q;
   logic polarity_q, rsp_valid_q, int_n_q;
   logic [15:0] ot_limit_q;
   logic [2:0] move_cnt_q;
   logic [7:0] timer_cnt_q;

   function automatic logic [8:0] tpr_mag(input logic [20:0] d);
      logic [20:0] a;
      a = d[20] ? 21'(-d) : d;
      tpr_mag = {d[20], (a > 21'h0000ff) ? 8'hff : a[7:0]};
   endfunction

   // Shadows stand still during a burst so one burst reads one sample
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         obj_q <= 17'h00000;
         amb_q <= 15'h0000;
         lp1_q <= 20'h00000;
         lp2_q <= 20'h00000;
         lp3_q <= 16'h0000;
      end else if (sample_stb && !burst_q) begin
         obj_q <= object_raw_reading;
         amb_q <= ambient_raw_reading;
         lp1_q <= object_filter_one;
         lp2_q <= object_filter_two;
         lp3_q <= ambient_filter_three;
      end
   end

   // ****************************************
   // Difference branches
   // ****************************************
   logic [20:0] pres_a, pres_b;
   logic [8:0] pres_m, move_m, step_m;
   logic move_due, ot_hit, timer_due;

   always_comb begin
      case (source_q)
         2'h0: begin
            pres_a = {1'b0, object_raw_reading, 3'h0};
            pres_b = {1'b0, object_filter_one};
         end
         2'h1: begin
            pres_a = {1'b0, object_raw_reading, 3'h0};
            pres_b = {1'b0, object_filter_two};
         end
         2'h2: begin
            pres_a = {1'b0, object_filter_one};
            pres_b = {1'b0, object_filter_two};
         end
         default: begin
            pres_a = {1'b0, object_filter_one};
            pres_b = {1'b0, cap_q[23:4]};
         end
      endcase
   end

   assign pres_m = tpr_mag(21'(pres_a - pres_b));
   assign move_m = tpr_mag(21'({1'b0, object_filter_one} - {1'b0, prev_lp1_q}));
   assign step_m = tpr_mag(21'({5'h00, ambient_raw_reading, 1'b0} - {5'h00, ambient_filter_three}));
   assign move_due = (move_cnt_q == 3'((4'h1 << interval_q) - 4'h1));
   assign ot_hit = polarity_q ? (object_filter_two[19:4] < ot_limit_q) : (object_filter_two[19:4] > ot_limit_q);
   assign timer_due = (periodic_q != 8'h00) && (timer_cnt_q == 8'(periodic_q - 8'h01));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         move_cnt_q <= 3'h0;
         prev_lp1_q <= 20'h00000;
         timer_cnt_q <= 8'h00;
      end else if (sample_stb) begin
         move_cnt_q <= move_due ? 3'h0 : 3'(move_cnt_q + 3'h1);
         if (move_due) begin
            prev_lp1_q <= object_filter_one;
         end
         timer_cnt_q <= (timer_due || periodic_q == 8'h00) ? 8'h00 : 8'(timer_cnt_q + 8'h01);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pres_q <= 8'h00;
         move_q <= 8'h00;
         step_q <= 8'h00;
         cap_q <= 24'h000000;
         live_q <= 8'h00;
      end else if (sample_stb) begin
         pres_q <= pres_m[7:0];
         step_q <= step_m[7:0];
         live_q[BIT_PRES_SIGN] <= pres_m[8];
         live_q[BIT_STEP_SIGN] <= step_m[8];
         live_q[BIT_PRES] <= pres_m[7:0] > pres_limit_q;
         live_q[BIT_STEP] <= step_m[7:0] > step_limit_q;
         live_q[BIT_OT] <= ot_hit;
         if (timer_due) begin
            live_q[BIT_TIMER] <= ~live_q[BIT_TIMER];
         end
         if (move_due) begin
            move_q <= move_m[7:0];
            live_q[BIT_MOVE_SIGN] <= move_m[8];
            live_q[BIT_MOVE] <= move_m[7:0] > move_limit_q;
            if (move_m[7:0] > move_limit_q) begin
               cap_q <= {object_filter_two, 4'h0};
            end
         end
      end
   end

   // ****************************************
   // Event latch and interrupt pin
   // ****************************************
   logic [7:0] ev_set;
   logic latch_read;

   always_comb begin
      ev_set = 8'h00;
      if (sample_stb) begin
         ev_set[BIT_PRES] = pres_m[7:0] > pres_limit_q;
         ev_set[BIT_PRES_SIGN] = ev_set[BIT_PRES] & pres_m[8];
         ev_set[BIT_STEP] = step_m[7:0] > step_limit_q;
         ev_set[BIT_STEP_SIGN] = ev_set[BIT_STEP] & step_m[8];
         ev_set[BIT_MOVE] = move_due && (move_m[7:0] > move_limit_q);
         ev_set[BIT_MOVE_SIGN] = ev_set[BIT_MOVE] & move_m[8];
         ev_set[BIT_OT] = ot_hit;
         ev_set[BIT_TIMER] = timer_due;
      end
   end

   assign latch_read = link.cmd_valid && (tpr_op_e'(link.cmd_op) == tpr_op_read) && (ptr_q == REG_EVENT_LATCH);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_q <= 8'h00;
      end else begin
         // An event in the clearing cycle survives the clear
         latch_q <= (latch_read ? 8'h00 : latch_q) | ev_set;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_n_q <= 1'b1;
      end else begin
         int_n_q <= ~|(latch_q[4:0] & mask_q);
      end
   end

   // ****************************************
   // Read mux
   // ****************************************
   logic [7:0] rd_byte;
   logic [7:0] nv_byte;
   logic [5:0] nv_idx;

   assign nv_idx = 6'(ptr_q - REG_NV_FIRST);
   assign nv_byte = nonvolatile_window[{nv_idx[4:0], 3'h0} +: 8];

   always_comb begin
      rd_byte = 8'h00;
      if (ptr_q == REG_OBJ_HI) begin
         rd_byte = obj_q[16:9];
      end else if (ptr_q == REG_OBJ_MID) begin
         rd_byte = obj_q[8:1];
      end else if (ptr_q == REG_OBJ_AMB) begin
         rd_byte = {obj_q[0], amb_q[14:8]};
      end else if (ptr_q == REG_AMB_LO) begin
         rd_byte = amb_q[7:0];
      end else if (ptr_q == REG_LP1_HI) begin
         rd_byte = lp1_q[19:12];
      end else if (ptr_q == REG_LP1_MID) begin
         rd_byte = lp1_q[11:4];
      end else if (ptr_q == REG_LP12) begin
         rd_byte = {lp1_q[3:0], lp2_q[19:16]};
      end else if (ptr_q == REG_LP2_MID) begin
         rd_byte = lp2_q[15:8];
      end else if (ptr_q == REG_LP2_LO) begin
         rd_byte = lp2_q[7:0];
      end else if (ptr_q == REG_LP3_HI) begin
         rd_byte = lp3_q[15:8];
      end else if (ptr_q == REG_LP3_LO) begin
         rd_byte = lp3_q[7:0];
      end else if (ptr_q == REG_CAP_HI) begin
         rd_byte = cap_q[23:16];
      end else if (ptr_q == REG_CAP_MID) begin
         rd_byte = cap_q[15:8];
      end else if (ptr_q == REG_CAP_LO) begin
         rd_byte = cap_q[7:0];
      end else if (ptr_q == REG_PRESENCE) begin
         rd_byte = pres_q;
      end else if (ptr_q == REG_MOVEMENT) begin
         rd_byte = move_q;
      end else if (ptr_q == REG_AMB_STEP) begin
         rd_byte = step_q;
      end else if (ptr_q == REG_EVENT_LATCH) begin
         rd_byte = latch_q;
      end else if (ptr_q == REG_LIVE_FLAGS) begin
         rd_byte = live_q;
      end else if (ptr_q == REG_SELECT_12) begin
         rd_byte = {filter_two_select, filter_one_select};
      end else if (ptr_q == REG_SELECT_3) begin
         rd_byte = {4'h0, filter_three_select};
      end else if (ptr_q == REG_PRES_LIMIT) begin
         rd_byte = pres_limit_q;
      end else if (ptr_q == REG_MOVE_LIMIT) begin
         rd_byte = move_limit_q;
      end else if (ptr_q == REG_STEP_LIMIT) begin
         rd_byte = step_limit_q;
      end else if (ptr_q == REG_MASK) begin
         rd_byte = {3'h0, mask_q};
      end else if (ptr_q == REG_MODE) begin
         rd_byte = {3'h0, polarity_q, source_q, interval_q};
      end else if (ptr_q == REG_PERIODIC) begin
         rd_byte = periodic_q;
      end else if (ptr_q == REG_OT_HI) begin
         rd_byte = ot_limit_q[15:8];
      end else if (ptr_q == REG_OT_LO) begin
         rd_byte = ot_limit_q[7:0];
      end else if (ptr_q == REG_NV_CTRL) begin
         rd_byte = nonvolatile_access_control;
      end else if (ptr_q >= REG_NV_FIRST && ptr_q <= REG_NV_LAST) begin
         rd_byte = nv_byte;
      end else if (ptr_q == REG_BUS_ADDR) begin
         rd_byte = bus_address_readback;
      end
   end

   // ****************************************
   // Link commands and writable fields
   // ****************************************
   logic do_write;
   tpr_op_e op;

   assign op = tpr_op_e'(link.cmd_op);
   assign do_write = link.cmd_valid && (op == tpr_op_write);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ptr_q <= 6'h00;
         burst_q <= 1'b0;
         rsp_valid_q <= 1'b0;
         rsp_data_q <= 8'h00;
      end else begin
         rsp_valid_q <= link.cmd_valid;
         if (link.cmd_valid) begin
            case (op)
               tpr_op_addr: begin
                  ptr_q <= link.cmd_data[5:0];
                  burst_q <= 1'b1;
               end
               tpr_op_write: begin
                  ptr_q <= 6'(ptr_q + 6'h01);
               end
               tpr_op_read: begin
                  rsp_data_q <= rd_byte;
                  ptr_q <= 6'(ptr_q + 6'h01);
               end
               default: begin
                  burst_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // Control fields reset to zero; software still sets them all before use
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filter_one_select <= 4'h0;
         filter_two_select <= 4'h0;
         filter_three_select <= 4'h0;
         pres_limit_q <= 8'h00;
         move_limit_q <= 8'h00;
         step_limit_q <= 8'h00;
         mask_q <= 5'h00;
         interval_q <= 2'h0;
         source_q <= 2'h0;
         polarity_q <= 1'b0;
         periodic_q <= 8'h00;
         ot_limit_q <= 16'h0000;
         nonvolatile_access_control <= 8'h00;
      end else if (do_write) begin
         if (ptr_q == REG_SELECT_12) begin
            filter_one_select <= link.cmd_data[3:0];
            filter_two_select <= link.cmd_data[7:4];
         end else if (ptr_q == REG_SELECT_3) begin
            filter_three_select <= link.cmd_data[3:0];
         end else if (ptr_q == REG_PRES_LIMIT) begin
            pres_limit_q <= link.cmd_data;
         end else if (ptr_q == REG_MOVE_LIMIT) begin
            move_limit_q <= link.cmd_data;
         end else if (ptr_q == REG_STEP_LIMIT) begin
            step_limit_q <= link.cmd_data;
         end else if (ptr_q == REG_MASK) begin
            mask_q <= link.cmd_data[4:0];
         end else if (ptr_q == REG_MODE) begin
            interval_q <= link.cmd_data[1:0];
            source_q <= link.cmd_data[3:2];
            polarity_q <= link.cmd_data[4];
         end else if (ptr_q == REG_PERIODIC) begin
            periodic_q <= link.cmd_data;
         end else if (ptr_q == REG_OT_HI) begin
            ot_limit_q[15:8] <= link.cmd_data;
         end else if (ptr_q == REG_OT_LO) begin
            ot_limit_q[7:0] <= link.cmd_data;
         end else if (ptr_q == REG_NV_CTRL) begin
            nonvolatile_access_control <= link.cmd_data;
         end
      end
   end

   assign link.rsp_valid = rsp_valid_q;
   assign link.rsp_data = rsp_data_q;
   assign link.int_n = int_n_q;
endmodule // tpr_bank

// ### inc/tpr_pkg.sv
// Constants shared by the thermopile result register bank and its controller.
// Assumes a single 200 MHz clock domain shared by both ends of the byte link.
// Notes on behaviour
// - Raw object reading: 17 bits, regs 1-3
// - Raw ambient reading: 15 bits, regs 3-4
// - Object filters one, two: 20 bits, eighths
// - Ambient filter: 16 bits, regs 10-11
// - Capture filter two on motion, 24 bits
// - Three 4-bit filter select fields, regs 20-21
// - Presence: 8-bit difference, pair by source
// - Deltas unsigned; signs in chip status
// - Motion: difference of successive filter-one samples
// - Motion sample spacing follows cycle time
// - Cycle time: reg 26 bits 1-0
// - Presence source: reg 26 bits 3-2
// - Host initializes every control register first
// - Reading event latch clears it, releases pin
// - Latched flags and mask drive interrupt pin
// - Pointer increments, wraps after 63 to 0
// - Writes to read-only locations are ignored
package tpr_pkg;
   // ****************************************
   // Link commands
   // ****************************************
   typedef enum logic [1:0] {tpr_op_addr, tpr_op_write, tpr_op_read, tpr_op_stop} tpr_op_e;

   // ****************************************
   // Device byte map
   // ****************************************
   localparam logic [5:0] REG_OBJ_HI = 6'h01;
   localparam logic [5:0] REG_OBJ_MID = 6'h02;
   localparam logic [5:0] REG_OBJ_AMB = 6'h03;
   localparam logic [5:0] REG_AMB_LO = 6'h04;
   localparam logic [5:0] REG_LP1_HI = 6'h05;
   localparam logic [5:0] REG_LP1_MID = 6'h06;
   localparam logic [5:0] REG_LP12 = 6'h07;
   localparam logic [5:0] REG_LP2_MID = 6'h08;
   localparam logic [5:0] REG_LP2_LO = 6'h09;
   localparam logic [5:0] REG_LP3_HI = 6'h0a;
   localparam logic [5:0] REG_LP3_LO = 6'h0b;
   localparam logic [5:0] REG_CAP_HI = 6'h0c;
   localparam logic [5:0] REG_CAP_MID = 6'h0d;
   localparam logic [5:0] REG_CAP_LO = 6'h0e;
   localparam logic [5:0] REG_PRESENCE = 6'h0f;
   localparam logic [5:0] REG_MOVEMENT = 6'h10;
   localparam logic [5:0] REG_AMB_STEP = 6'h11;
   localparam logic [5:0] REG_EVENT_LATCH = 6'h12;
   localparam logic [5:0] REG_LIVE_FLAGS = 6'h13;
   localparam logic [5:0] REG_SELECT_12 = 6'h14;
   localparam logic [5:0] REG_SELECT_3 = 6'h15;
   localparam logic [5:0] REG_PRES_LIMIT = 6'h16;
   localparam logic [5:0] REG_MOVE_LIMIT = 6'h17;
   localparam logic [5:0] REG_STEP_LIMIT = 6'h18;
   localparam logic [5:0] REG_MASK = 6'h19;
   localparam logic [5:0] REG_MODE = 6'h1a;
   localparam logic [5:0] REG_PERIODIC = 6'h1b;
   localparam logic [5:0] REG_OT_HI = 6'h1c;
   localparam logic [5:0] REG_OT_LO = 6'h1d;
   localparam logic [5:0] REG_NV_CTRL = 6'h1f;
   localparam logic [5:0] REG_NV_FIRST = 6'h20;
   localparam logic [5:0] REG_NV_LAST = 6'h3e;
   localparam logic [5:0] REG_BUS_ADDR = 6'h3f;

   // Flag and sign positions in the latch and live flag registers
   localparam int BIT_TIMER = 0;
   localparam int BIT_STEP = 1;
   localparam int BIT_MOVE = 2;
   localparam int BIT_PRES = 3;
   localparam int BIT_OT = 4;
   localparam int BIT_STEP_SIGN = 5;
   localparam int BIT_MOVE_SIGN = 6;
   localparam int BIT_PRES_SIGN = 7;

   // ****************************************
   // Controller APB map
   // ****************************************
   localparam logic [7:0] APB_CMD = 8'h00;
   localparam logic [7:0] APB_STATUS = 8'h04;
   localparam logic [7:0] APB_IRQ_STATUS = 8'h08;
   localparam logic [7:0] APB_IRQ_CLEAR = 8'h0c;
   localparam logic [7:0] APB_IRQ_ENABLE = 8'h10;
   localparam int CMD_ADDR_POS = 8;
   localparam int CMD_OP_POS = 16;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_DEVICE = 1;
   localparam int IRQ_WIDTH = 2;
endpackage

// ### inc/tpr_link_if.sv
// Byte link between the register bank and its controller.
// Both ends run on the same pclk; one command per response.
`timescale 1ns/1ps
interface tpr_link_if;
   logic cmd_valid;
   logic [1:0] cmd_op;
   logic [7:0] cmd_data;
   logic rsp_valid;
   logic [7:0] rsp_data;
   logic int_n;
   modport dev (input cmd_valid, input cmd_op, input cmd_data, output rsp_valid, output rsp_data, output int_n);
   modport host (output cmd_valid, output cmd_op, output cmd_data, input rsp_valid, input rsp_data, input int_n);
endinterface

// ### design/tpr_ctrl.sv
// Controller end: takes byte commands from software over APB and runs them on the link.
// Assumes the bank answers each command; only one command is outstanding at a time.
`timescale 1ns/1ps
module tpr_ctrl (
   input wire logic pclk,
   input wire logic presetn,
   tpr_link_if.host link,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq
);
   import tpr_pkg::*;

   // ****************************************
   // APB slave
   // ****************************************
   logic pready_q, busy_q, cmd_valid_q, int_n_prev_q, irq_q;
   logic [31:0] prdata_q;
   logic [1:0] cmd_op_q;
   logic [7:0] cmd_data_q, rdata_q;
   logic [IRQ_WIDTH-1:0] irq_st_q, irq_en_q, irq_set, irq_clr;
   logic acc, wr, rd;

   // One wait state keeps every APB output registered
   assign acc = psel && penable && pready_q;
   assign wr = acc && pwrite;
   assign rd = psel && penable && !pready_q && !pwrite;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
      end else begin
         pready_q <= psel && penable && !pready_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h00000000;
      end else if (rd) begin
         if (paddr == APB_STATUS) begin
            prdata_q <= {16'h0000, rdata_q, 7'h00, busy_q};
         end else if (paddr == APB_IRQ_STATUS) begin
            prdata_q <= {30'h00000000, irq_st_q};
         end else if (paddr == APB_IRQ_ENABLE) begin
            prdata_q <= {30'h00000000, irq_en_q};
         end else begin
            prdata_q <= 32'h00000000;
         end
      end
   end

   // ****************************************
   // Link command issue
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_q <= 1'b0;
         cmd_valid_q <= 1'b0;
         cmd_op_q <= 2'h0;
         cmd_data_q <= 8'h00;
         rdata_q <= 8'h00;
      end else begin
         cmd_valid_q <= 1'b0;
         if (wr && paddr == APB_CMD && !busy_q) begin
            cmd_op_q <= pwdata[CMD_OP_POS +: 2];
            cmd_data_q <= (tpr_op_e'(pwdata[CMD_OP_POS +: 2]) == tpr_op_addr) ?
               {2'h0, pwdata[CMD_ADDR_POS +: 6]} : pwdata[7:0];
            cmd_valid_q <= 1'b1;
            busy_q <= 1'b1;
         end else if (link.rsp_valid && busy_q) begin
            busy_q <= 1'b0;
            if (tpr_op_e'(cmd_op_q) == tpr_op_read) begin
               rdata_q <= link.rsp_data;
            end
         end
      end
   end

   // ****************************************
   // Interrupts
   // ****************************************
   always_comb begin
      irq_set = '0;
      irq_set[IRQ_DONE] = link.rsp_valid && busy_q;
      irq_set[IRQ_DEVICE] = int_n_prev_q && !link.int_n;
      irq_clr = (wr && paddr == APB_IRQ_CLEAR) ? pwdata[IRQ_WIDTH-1:0] : '0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_st_q <= '0;
         irq_en_q <= '0;
         int_n_prev_q <= 1'b1;
         irq_q <= 1'b0;
      end else begin
         int_n_prev_q <= link.int_n;
         irq_st_q <= (irq_st_q & ~irq_clr) | irq_set;
         if (wr && paddr == APB_IRQ_ENABLE) begin
            irq_en_q <= pwdata[IRQ_WIDTH-1:0];
         end
         irq_q <= |(((irq_st_q & ~irq_clr) | irq_set) & irq_en_q);
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = 1'b0;
   assign irq = irq_q;
   assign link.cmd_valid = cmd_valid_q;
   assign link.cmd_op = cmd_op_q;
   assign link.cmd_data = cmd_data_q;
endmodule // tpr_ctrl

// ### dv/tpr_link_assertions.sv
// Checker for the byte link between the register bank and its controller.
// Assumes one pclk domain; instantiated beside the link interface.
`timescale 1ns/1ps
module tpr_link_assertions (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cmd_valid,
   input wire logic [1:0] cmd_op,
   input wire logic [7:0] cmd_data,
   input wire logic rsp_valid,
   input wire logic [7:0] rsp_data,
   input wire logic int_n
);
   // ****************
   // Pointer shadow
   // ****************
   logic [5:0] ptr_q;
   logic [5:0] rd_q;
   logic rdv_q;
   logic [4:0] mask_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ptr_q <= 6'h00;
         rd_q <= 6'h00;
         rdv_q <= 1'b0;
         mask_q <= 5'h00;
      end else begin
         rdv_q <= cmd_valid && cmd_op == 2'h2;
         if (cmd_valid) begin
            rd_q <= ptr_q;
            // Only reads and writes step the pointer; 6 bits wrap 63 to 0
            ptr_q <= (cmd_op == 2'h0) ? cmd_data[5:0] : ptr_q + {5'h00, ^cmd_op};
            if (cmd_op == 2'h1 && ptr_q == 6'h19) begin
               mask_q <= cmd_data[4:0];
            end
         end
      end
   end
   // ****************
   // Properties
   // ****************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   rsp_follow_a: assert property (cmd_valid |=> rsp_valid) else $error("no response");
   rsp_cause_a: assert property (rsp_valid |-> $past(cmd_valid)) else $error("stray response");
   rsp_hold_a: assert property (rsp_valid && !rdv_q |-> $stable(rsp_data)) else $error("data moved");
   rsv_zero_a: assert property (rsp_valid && rdv_q && (rd_q == 6'h00 || rd_q == 6'h1e) |-> rsp_data == 8'h00)
      else $error("reserved byte not zero");
   nib_rsv_a: assert property (rsp_valid && rdv_q && rd_q == 6'h15 |-> rsp_data[7:4] == 4'h0)
      else $error("reserved nibble set");
   mask_rsv_a: assert property (rsp_valid && rdv_q && rd_q == 6'h19 |-> rsp_data[7:5] == 3'h0)
      else $error("mask reserved set");
   mode_rsv_a: assert property (rsp_valid && rdv_q && rd_q == 6'h1a |-> rsp_data[7:5] == 3'h0)
      else $error("mode reserved set");
   pin_low_a: assert property (rsp_valid && rdv_q && rd_q == 6'h12 && |(rsp_data[4:0] & mask_q) |-> !int_n)
      else $error("pin not asserted");
   pin_off_a: assert property (mask_q == 5'h00 |=> int_n) else $error("pin low while masked");
   latch_rd_c: cover property (rsp_valid && rdv_q && rd_q == 6'h12);
   wrap_rd_c: cover property (rsp_valid && rdv_q && rd_q == 6'h00);
   wr_c: cover property (cmd_valid && cmd_op == 2'h1);
endmodule // tpr_link_assertions

// ### dv/thermopile_result_register_map_tb.sv
// Bench joining the register bank and controller; software side driven over APB.
// Assumes the package and link interface are compiled first.
`timescale 1ns/1ps
module thermopile_result_register_map_tb;
   import tpr_pkg::*;
   // ****************
   // Stimulus state
   // ****************
   localparam logic [7:0] CFG [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h08, 8'h00, 8'h00, 8'hff, 8'hff};
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stb = 1'b0;
   logic [7:0] paddr = 8'h00, sad = 8'h00, b, nvc;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, irq;
   logic [16:0] obj = 17'h0;
   logic [14:0] amb = 15'h0;
   logic [19:0] lp1 = 20'h0, lp2 = 20'h0;
   logic [15:0] lp3 = 16'h0;
   logic [247:0] nvw = 248'h0;
   logic [3:0] s1, s2, s3;
   logic [87:0] ex;
   logic [7:0] wv [13];
   int n_fail = 0, n_checks = 0, seed = 55;
   always #2.5 pclk = ~pclk;
   tpr_link_if link ();
   tpr_bank tpr_bank_i (.pclk(pclk), .presetn(presetn), .link(link.dev), .sample_stb(stb),
      .object_raw_reading(obj), .ambient_raw_reading(amb), .object_filter_one(lp1), .object_filter_two(lp2),
      .ambient_filter_three(lp3), .nonvolatile_window(nvw), .bus_address_readback(sad),
      .filter_one_select(s1), .filter_two_select(s2), .filter_three_select(s3), .nonvolatile_access_control(nvc));
   tpr_ctrl tpr_ctrl_i (.pclk(pclk), .presetn(presetn), .link(link.host), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(), .irq(irq));
   tpr_link_assertions tpr_link_assertions_i (.pclk(pclk), .presetn(presetn), .cmd_valid(link.cmd_valid),
      .cmd_op(link.cmd_op), .cmd_data(link.cmd_data), .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data),
      .int_n(link.int_n));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // One link command, then poll until the controller is idle again
   task automatic lk(input logic [1:0] op, input logic [7:0] d);
      int k;
      k = 0;
      apb(1'b1, APB_CMD, {14'h0, op, 2'b00, d[5:0], d});
      do begin
         apb(1'b0, APB_STATUS, 32'h0);
         k++;
      end while (rd[0] !== 1'b0 && k < 50);
      if (rd[0] !== 1'b0) n_fail++;
      b = rd[15:8];
   endtask
   task automatic rdb(input logic [7:0] e);
      lk(2'h2, 8'h00);
      chk(b, e);
   endtask
   task automatic smp;
      @(posedge pclk);
      stb <= 1'b1;
      @(posedge pclk);
      stb <= 1'b0;
   endtask
   function automatic logic [7:0] wmask(input int a);
      case (a)
         21: return 8'h0f;
         25, 26: return 8'h1f;
         30: return 8'h00;
         default: return 8'hff;
      endcase
   endfunction
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #100000;
      n_fail++;
      end_sim;
   end
   // ****************
   // Scenarios
   // ****************
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      for (int r = 0; r < 4; r++) begin
         ex = (r == 0) ? '1 : 88'({$random(seed), $random(seed), $random(seed)});
         {obj, amb, lp1, lp2, lp3} <= ex;
         smp;
         lk(2'h0, 8'h01);
         // A new sample mid-burst must not tear the multi-byte values
         {obj, amb, lp1, lp2, lp3} <= ~ex;
         smp;
         for (int i = 10; i >= 0; i--) rdb(ex[i*8 +: 8]);
         lk(2'h3, 8'h00);
      end
      sad <= 8'($random(seed));
      nvw[7:0] <= 8'h5a;
      lk(2'h0, 8'h3f);
      rdb(sad);
      rdb(8'h00);
      lk(2'h0, 8'h14);
      for (int a = 20; a < 33; a++) begin
         wv[a-20] = 8'($random(seed));
         lk(2'h1, wv[a-20]);
      end
      chk({s2, s1, s3, nvc}, {wv[0], wv[1][3:0], wv[11]});
      lk(2'h0, 8'h14);
      for (int a = 20; a < 33; a++) rdb((a == 32) ? 8'h5a : wv[a-20] & wmask(a));
      {obj, amb, lp1, lp2, lp3} <= {17'h64, 15'h0, 20'h348, 20'h33e, 16'h0};
      apb(1'b1, APB_IRQ_ENABLE, 32'h2);
      for (int s = 0; s < 3; s++) begin
         lk(2'h0, 8'h14);
         for (int i = 0; i < 10; i++) lk(2'h1, (i == 6) ? 8'(s << 2) : CFG[i]);
         smp;
         lk(2'h0, 8'h0f);
         rdb(s == 0 ? 8'h28 : s == 1 ? 8'h1e : 8'h0a);
      end
      lk(2'h0, 8'h0c);
      for (int i = 4; i >= 0; i--) rdb(8'(40'h0033e00a00 >> i * 8));
      chk({link.int_n, irq}, 2'b01);
      lk(2'h0, 8'h12);
      lk(2'h2, 8'h00);
      chk(b[3], 1'b1);
      lk(2'h0, 8'h12);
      rdb(8'h00);
      chk(link.int_n, 1'b1);
      apb(1'b1, APB_IRQ_CLEAR, 32'h3);
      apb(1'b0, APB_IRQ_STATUS, 32'h0);
      chk({rd[1:0], irq}, 3'h0);
      end_sim;
   end
endmodule // thermopile_result_register_map_tb
